// [serial_pkg.sv]
package serial_pkg;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W   = 16;
  localparam int DATA_W   = 8;
  localparam int NUM_CH   = 2;
  localparam int CH_SHIFT = 4;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] A_PRIO  = 16'hff21;
  localparam logic [ADDR_W-1:0] A_EN    = 16'hff24;
  localparam logic [ADDR_W-1:0] A_FLAG  = 16'hff27;
  localparam logic [ADDR_W-1:0] A_MODE0 = 16'hff48;
  localparam logic [ADDR_W-1:0] A_CTRL0 = 16'hff49;
  localparam logic [ADDR_W-1:0] A_IR0   = 16'hff4b;
  localparam logic [ADDR_W-1:0] A_MODE1 = 16'hff4c;
  localparam logic [ADDR_W-1:0] A_CTRL1 = 16'hff4d;
  localparam logic [ADDR_W-1:0] A_IR1   = 16'hff4f;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int B_TXEN     = 0;
  localparam int B_TXTRG    = 1;
  localparam int B_RXEN     = 2;
  localparam int B_RXTRG    = 3;
  localparam int B_OER      = 4;
  localparam int B_PER      = 5;
  localparam int B_FER      = 6;
  localparam int B_IR_MODE  = 4;
  localparam int B_IR_IINV  = 6;
  localparam int B_IR_OINV  = 7;
  localparam int B_SYNC     = 0;
  localparam int B_ODD      = 5;
  localparam int B_PAR_EN   = 6;
  localparam int B_EV_TX    = 0;
  localparam int B_EV_RX    = 1;
  localparam int B_EV_ERR   = 2;
  localparam int PRIO_W     = 2;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_RDATA = 8'h00;
  localparam logic [2:0]        RST_EV    = 3'h0;
  localparam logic [PRIO_W-1:0] RST_PRIO  = 2'h0;
  localparam logic              RST_BIT   = 1'b0;
  localparam logic              LINE_IDLE = 1'b1;

endpackage

// [irda_line.sv]
`timescale 1ns/100ps
module irda_line (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ir_mode,
  input  wire logic out_inv,
  input  wire logic in_inv,
  input  wire logic tx_bit,
  input  wire logic tx_pulse,
  input  wire logic pin_in,
  output logic      pin_out,
  output logic      rx_bit
);
  import serial_pkg::*;

  typedef struct packed {
    logic pin_out;
    logic rx_bit;
  } line_s;

  line_s q;
  line_s d;

  // ---------------------------------------------------------------
  // Line encoding
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    if (ir_mode) begin
      d.pin_out = out_inv ? tx_pulse : ~tx_pulse;  // [R7]
      d.rx_bit  = in_inv ? ~pin_in : pin_in;       // [R8]
    end else begin
      d.pin_out = tx_bit;                          // [R6]
      d.rx_bit  = pin_in;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q.pin_out <= LINE_IDLE;
      q.rx_bit  <= LINE_IDLE;
    end else begin
      q <= d;
    end
  end

  assign pin_out = q.pin_out;
  assign rx_bit  = q.rx_bit;

endmodule

// [serial_error_irda_interrupt.sv]
// How it works
// [R1] Async mode with parity on: bad received parity sets the parity error flag.
// [R2] Writing one clears the parity error flag; zero leaves it.
// [R3] Parity and framing errors are zero at reset and while receive is disabled.
// [R4] Async reception with a zero stop bit sets the framing error flag.
// [R5] Writing one clears the framing error flag; zero does nothing.
// [R6] Per-channel bit picks infrared pulses or plain line; resets zero, readable.
// [R7] Output inversion: zero bits high pulses, idle low; else low pulses, idle high.
// [R8] Input inversion: high pulse is zero; else low pulse is zero; resets zero.
// [R9] Two-bit priority per channel: 3, 2, 1 levels, 00 means none.
// [R10] Three readable enables per channel, bits 0-2 and 4-6, reset disabled.
// [R11] Factor flags set regardless of enable and priority.
// [R12] Transmit-done flag sets when the shifter finishes sending.
// [R13] Receive-done flag sets when the character reaches the receive buffer.
// [R14] Receive-error flag sets on parity, framing or overrun error.
// [R15] Request only when flag, enable set and priority above CPU mask.
// [R16] Factor flags clear on one, ignore zero, reset to zero.
// [R17] Software changes mode only with both enables zero.
// [R18] Software never retriggers a busy operation and disables before sleep.
// [R19] Clock-synchronous mode is half duplex; software never overlaps directions.
// [R20] Error flag rises half a serial clock before the receive-done flag.
// [R21] Overrun sets no receive-done flag and no receive-done request.
// [R22] Software starts the oscillator and waits before any transfer.
// [R23] Async: completion before the receive trigger acknowledge flags overrun.
// [R24] Parity on: received MSB is checked parity; transmit gets parity appended.
// [R25] Two identical independent channels.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
module serial_error_irda_interrupt (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic [serial_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [serial_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [serial_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic [serial_pkg::PRIO_W-1:0] cpu_irq_mask,
  input  wire logic [1:0]                    rx_char_done,
  input  wire logic [7:0]                    rx_char_0,
  input  wire logic [7:0]                    rx_char_1,
  input  wire logic [1:0]                    rx_stop_bit,
  input  wire logic [1:0]                    serial_half_tick,
  input  wire logic [1:0]                    tx_shift_done,
  input  wire logic [7:0]                    tx_char_0,
  input  wire logic [7:0]                    tx_char_1,
  input  wire logic [1:0]                    tx_serial_bit,
  input  wire logic [1:0]                    tx_ir_pulse,
  input  wire logic [1:0]                    rx_line_pin,
  output logic      [1:0]                    serial_output_pin,
  output logic      [1:0]                    rx_line_bit,
  output logic      [1:0]                    tx_parity_bit,
  output logic      [1:0]                    tx_start,
  output logic      [1:0]                    rx_start,
  output logic      [1:0]                    transmit_enable_bit,
  output logic      [1:0]                    receive_enable_bit,
  output logic      [1:0]                    clock_sync_mode,
  output logic                               irq_request,
  output logic      [serial_pkg::PRIO_W-1:0] irq_level
);
  import serial_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic              txen;
    logic              txtrg;
    logic              rxen;
    logic              rxtrg;
    logic              oer;
    logic              per;
    logic              fer;
    logic              ir_mode;
    logic              ir_in_inv;
    logic              ir_out_inv;
    logic              sync_mode;
    logic              odd;
    logic              par_en;
    logic              buf_full;
    logic              done_pending;
    logic [2:0]        en;
    logic [2:0]        flag;
    logic [PRIO_W-1:0] prio;
    logic              tx_start;
    logic              rx_start;
    logic              tx_par;
  } ch_s;

  typedef struct packed {
    ch_s [NUM_CH-1:0]  ch;
    logic [DATA_W-1:0] rdata;
    logic              irq;
    logic [PRIO_W-1:0] level;
  } top_s;

  top_s q;
  top_s d;

  logic [7:0] rx_char [NUM_CH];
  logic [7:0] tx_char [NUM_CH];

  assign rx_char[0] = rx_char_0;
  assign rx_char[1] = rx_char_1;
  assign tx_char[0] = tx_char_0;
  assign tx_char[1] = tx_char_1;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [ADDR_W-1:0] a_ctrl;
    logic [ADDR_W-1:0] a_ir;
    logic [ADDR_W-1:0] a_mode;
    logic [2:0]        wr_ev;
    logic              bad_par;
    logic              req;
    logic [PRIO_W-1:0] best;
    logic              busy_rx;
    logic              busy_tx;
    a_ctrl  = A_CTRL0;
    a_ir    = A_IR0;
    a_mode  = A_MODE0;
    wr_ev   = RST_EV;
    bad_par = 1'b0;
    req     = 1'b0;
    best    = RST_PRIO;
    busy_rx = 1'b0;
    busy_tx = 1'b0;
    d       = q;
    for (int i = 0; i < NUM_CH; i++) begin  // [R25]
      a_ctrl = (i == 0) ? A_CTRL0 : A_CTRL1;
      a_ir   = (i == 0) ? A_IR0 : A_IR1;
      a_mode = (i == 0) ? A_MODE0 : A_MODE1;
      d.ch[i].tx_start = 1'b0;
      d.ch[i].rx_start = 1'b0;
      d.ch[i].tx_par   = (^tx_char[i]) ^ q.ch[i].odd;  // [R24]
      busy_rx          = q.ch[i].sync_mode && q.ch[i].rxtrg;  // [R19]
      busy_tx          = q.ch[i].sync_mode && q.ch[i].txtrg;  // [R19]

      // Software writes
      if (reg_wr) begin
        if (reg_addr == a_ctrl) begin
          d.ch[i].txen = reg_wdata[B_TXEN];
          d.ch[i].rxen = reg_wdata[B_RXEN];
          if (reg_wdata[B_TXTRG] && reg_wdata[B_TXEN] && !busy_rx) begin  // [R19]
            d.ch[i].txtrg    = 1'b1;
            d.ch[i].tx_start = 1'b1;
          end
          if (reg_wdata[B_RXTRG] && reg_wdata[B_RXEN] && !busy_tx) begin  // [R19]
            d.ch[i].rxtrg    = 1'b1;
            d.ch[i].rx_start = 1'b1;
            d.ch[i].buf_full = 1'b0;  // [R23]
          end
          if (reg_wdata[B_OER]) begin
            d.ch[i].oer = 1'b0;
          end
          if (reg_wdata[B_PER]) begin
            d.ch[i].per = 1'b0;  // [R2]
          end
          if (reg_wdata[B_FER]) begin
            d.ch[i].fer = 1'b0;  // [R5]
          end
        end else if (reg_addr == a_ir) begin
          d.ch[i].ir_mode    = reg_wdata[B_IR_MODE];  // [R6]
          d.ch[i].ir_in_inv  = reg_wdata[B_IR_IINV];  // [R8]
          d.ch[i].ir_out_inv = reg_wdata[B_IR_OINV];  // [R7]
        end else if (reg_addr == a_mode) begin
          d.ch[i].sync_mode = reg_wdata[B_SYNC];
          d.ch[i].odd       = reg_wdata[B_ODD];
          d.ch[i].par_en    = reg_wdata[B_PAR_EN];
        end else if (reg_addr == A_EN) begin
          d.ch[i].en = reg_wdata[i*CH_SHIFT +: 3];  // [R10]
        end else if (reg_addr == A_FLAG) begin
          wr_ev = reg_wdata[i*CH_SHIFT +: 3];
          d.ch[i].flag = q.ch[i].flag & ~wr_ev;  // [R16]
        end else if (reg_addr == A_PRIO) begin
          d.ch[i].prio = reg_wdata[i*PRIO_W +: PRIO_W];  // [R9]
        end
      end

      // Hardware events, set wins over a clear in the same cycle
      if (tx_shift_done[i] && q.ch[i].txen) begin
        d.ch[i].txtrg = 1'b0;
        d.ch[i].flag[B_EV_TX] = 1'b1;  // [R11] [R12]
      end
      if (rx_char_done[i] && q.ch[i].rxen) begin
        if (q.ch[i].sync_mode) begin
          d.ch[i].rxtrg        = 1'b0;
          d.ch[i].done_pending = 1'b1;
        end else if (q.ch[i].buf_full) begin
          d.ch[i].oer = 1'b1;  // [R23]
          d.ch[i].flag[B_EV_ERR] = 1'b1;  // [R14] [R21]
        end else begin
          bad_par = (^rx_char[i]) ^ q.ch[i].odd;
          if (q.ch[i].par_en && bad_par) begin
            d.ch[i].per = 1'b1;  // [R1] [R24]
            d.ch[i].flag[B_EV_ERR] = 1'b1;  // [R14]
          end
          if (!rx_stop_bit[i]) begin
            d.ch[i].fer = 1'b1;  // [R4]
            d.ch[i].flag[B_EV_ERR] = 1'b1;  // [R14]
          end
          d.ch[i].buf_full     = 1'b1;
          d.ch[i].done_pending = 1'b1;  // [R20]
        end
      end
      if (serial_half_tick[i] && q.ch[i].done_pending) begin
        d.ch[i].done_pending = 1'b0;
        d.ch[i].flag[B_EV_RX] = 1'b1;  // [R13] [R20]
      end

      // Receive disable forces the error state clear
      if (!d.ch[i].rxen) begin
        d.ch[i].oer          = 1'b0;
        d.ch[i].per          = 1'b0;  // [R3]
        d.ch[i].fer          = 1'b0;  // [R3]
        d.ch[i].rxtrg        = 1'b0;
        d.ch[i].buf_full     = 1'b0;
        d.ch[i].done_pending = 1'b0;
      end
      if (!d.ch[i].txen) begin
        d.ch[i].txtrg = 1'b0;
      end

      // Interrupt request
      if ((|(q.ch[i].flag & q.ch[i].en)) && (q.ch[i].prio > cpu_irq_mask)) begin  // [R15]
        req = 1'b1;
        if (q.ch[i].prio > best) begin
          best = q.ch[i].prio;
        end
      end
    end
    d.irq   = req;
    d.level = best;

    // Read data
    if (!reg_rd) begin
      d.rdata = RST_RDATA;
    end else if (reg_addr == A_PRIO) begin
      d.rdata = {4'h0, q.ch[1].prio, q.ch[0].prio};
    end else if (reg_addr == A_EN) begin
      d.rdata = {1'b0, q.ch[1].en, 1'b0, q.ch[0].en};  // [R10]
    end else if (reg_addr == A_FLAG) begin
      d.rdata = {1'b0, q.ch[1].flag, 1'b0, q.ch[0].flag};
    end else if (reg_addr == A_CTRL0 || reg_addr == A_CTRL1) begin
      d.rdata = (reg_addr == A_CTRL0)
              ? {1'b0, q.ch[0].fer, q.ch[0].per, q.ch[0].oer,
                 q.ch[0].rxtrg, q.ch[0].rxen, q.ch[0].txtrg, q.ch[0].txen}
              : {1'b0, q.ch[1].fer, q.ch[1].per, q.ch[1].oer,
                 q.ch[1].rxtrg, q.ch[1].rxen, q.ch[1].txtrg, q.ch[1].txen};
    end else if (reg_addr == A_IR0) begin
      d.rdata = {q.ch[0].ir_out_inv, q.ch[0].ir_in_inv, 1'b0, q.ch[0].ir_mode, 4'h0};  // [R6]
    end else if (reg_addr == A_IR1) begin
      d.rdata = {q.ch[1].ir_out_inv, q.ch[1].ir_in_inv, 1'b0, q.ch[1].ir_mode, 4'h0};  // [R6]
    end else if (reg_addr == A_MODE0) begin
      d.rdata = {1'b0, q.ch[0].par_en, q.ch[0].odd, 4'h0, q.ch[0].sync_mode};
    end else if (reg_addr == A_MODE1) begin
      d.rdata = {1'b0, q.ch[1].par_en, q.ch[1].odd, 4'h0, q.ch[1].sync_mode};
    end else begin
      d.rdata = RST_RDATA;
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;  // [R3] [R6] [R8] [R9] [R10] [R16]
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // Line stages and outputs
  // ---------------------------------------------------------------
  for (genvar g = 0; g < NUM_CH; g++) begin : g_line
    irda_line u_line (
      .clk      (clk),
      .rst      (rst),
      .ir_mode  (q.ch[g].ir_mode),
      .out_inv  (q.ch[g].ir_out_inv),
      .in_inv   (q.ch[g].ir_in_inv),
      .tx_bit   (tx_serial_bit[g]),
      .tx_pulse (tx_ir_pulse[g]),
      .pin_in   (rx_line_pin[g]),
      .pin_out  (serial_output_pin[g]),
      .rx_bit   (rx_line_bit[g])
    );
    assign tx_parity_bit[g]       = q.ch[g].tx_par;
    assign tx_start[g]            = q.ch[g].tx_start;
    assign rx_start[g]            = q.ch[g].rx_start;
    assign transmit_enable_bit[g] = q.ch[g].txen;
    assign receive_enable_bit[g]  = q.ch[g].rxen;
    assign clock_sync_mode[g]     = q.ch[g].sync_mode;
  end

  assign reg_rdata   = q.rdata;
  assign irq_request = q.irq;
  assign irq_level   = q.level;

endmodule

// [serial_chk.sv]
`timescale 1ns/100ps
module serial_chk (
  input wire logic                          clk,
  input wire logic                          rst,
  input wire logic [serial_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [serial_pkg::DATA_W-1:0] reg_wdata,
  input wire logic                          reg_wr,
  input wire logic                          reg_rd,
  input wire logic [serial_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [serial_pkg::PRIO_W-1:0] cpu_irq_mask,
  input wire logic [1:0]                    tx_start,
  input wire logic [1:0]                    transmit_enable_bit,
  input wire logic [1:0]                    receive_enable_bit,
  input wire logic [1:0]                    clock_sync_mode,
  input wire logic [1:0]                    serial_output_pin,
  input wire logic                          irq_request,
  input wire logic [serial_pkg::PRIO_W-1:0] irq_level
);
  import serial_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ----------
  // Assertions and covers
  // ----------
  reset_state_a: assert property (disable iff (1'b0)
    rst |=> reg_rdata == 8'h00 && !irq_request && serial_output_pin == 2'h3)
    else $error("outputs not cleared by reset");
  read_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
  ctrl_read_a: assert property (reg_rd && reg_addr == A_CTRL0 |=>
    reg_rdata[B_TXEN] == $past(transmit_enable_bit[0]) &&
    reg_rdata[B_RXEN] == $past(receive_enable_bit[0]))
    else $error("control read differs from enables");
  enable_write_a: assert property (reg_wr && reg_addr == A_CTRL1 |=>
    receive_enable_bit[1] == $past(reg_wdata[B_RXEN]) &&
    transmit_enable_bit[1] == $past(reg_wdata[B_TXEN]))
    else $error("channel 1 enables not written");
  sync_write_a: assert property (reg_wr && reg_addr == A_MODE0 |=>
    clock_sync_mode[0] == $past(reg_wdata[B_SYNC]))
    else $error("sync mode not written");
  start_pulse_a: assert property (tx_start[0] |=> !tx_start[0])
    else $error("transmit start longer than one cycle");
  level_valid_a: assert property (irq_request |-> irq_level != 2'h0)
    else $error("request with level zero");
  mask_block_a: assert property (cpu_irq_mask == 2'h3 |=> !irq_request)
    else $error("request above top mask level");
  irq_seen_c: cover property ($rose(irq_request));
  tx_seen_c: cover property (tx_start[0]);
  ctrl_seen_c: cover property (reg_rd && reg_addr == A_CTRL0);
endmodule

bind serial_error_irda_interrupt serial_chk u_chk (
  .clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_irq_mask,
  .tx_start, .transmit_enable_bit, .receive_enable_bit, .clock_sync_mode,
  .serial_output_pin, .irq_request, .irq_level
);

// [far_end.sv]
`timescale 1ns/100ps
module far_end (
  input  wire logic  clk,
  output logic [1:0] rx_char_done,
  output logic [7:0] rx_char_0,
  output logic [7:0] rx_char_1,
  output logic [1:0] rx_stop_bit,
  output logic [1:0] serial_half_tick,
  output logic [1:0] tx_shift_done,
  output logic [7:0] tx_char_0,
  output logic [7:0] tx_char_1,
  output logic [1:0] tx_serial_bit,
  output logic [1:0] tx_ir_pulse,
  output logic [1:0] rx_line_pin
);
  // ----------
  // Idle line
  // ----------
  initial begin
    rx_char_done = 2'h0;
    rx_char_0 = 8'h00;
    rx_char_1 = 8'h00;
    rx_stop_bit = 2'h3;
    serial_half_tick = 2'h0;
    tx_shift_done = 2'h0;
    tx_char_0 = 8'h00;
    tx_char_1 = 8'h00;
    tx_serial_bit = 2'h3;
    tx_ir_pulse = 2'h0;
    rx_line_pin = 2'h3;
  end
  // ----------
  // Receive, transmit and line engine events
  // ----------
  task deliver(input int ch, input logic [7:0] c, input logic s);
    @(posedge clk);
    rx_char_done[ch] <= 1'b1;
    rx_char_0 <= c;
    rx_char_1 <= c;
    rx_stop_bit[ch] <= s;
    @(posedge clk);
    rx_char_done[ch] <= 1'b0;
    rx_char_0 <= ~c;
    rx_char_1 <= ~c;
    rx_stop_bit[ch] <= ~s;
  endtask
  task tick(input int ch);
    @(posedge clk);
    serial_half_tick[ch] <= 1'b1;
    @(posedge clk);
    serial_half_tick[ch] <= 1'b0;
  endtask
  task shifted(input int ch);
    @(posedge clk);
    tx_shift_done[ch] <= 1'b1;
    @(posedge clk);
    tx_shift_done[ch] <= 1'b0;
  endtask
  task txchar(input logic [7:0] c);
    @(posedge clk);
    tx_char_0 <= c;
    tx_char_1 <= c;
  endtask
  task line(input int ch, input logic p);
    @(posedge clk);
    tx_ir_pulse[ch] <= p;
    tx_serial_bit[ch] <= ~p;
    rx_line_pin[ch] <= p;
  endtask
endmodule

// [tb_top.sv]
`timescale 1ns/100ps
module tb_top;
  import serial_pkg::*;
  logic              clk, rst, reg_wr, reg_rd, irq_request;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic [1:0]        cpu_irq_mask, irq_level, rx_char_done, rx_stop_bit, serial_half_tick;
  logic [1:0]        tx_shift_done, tx_serial_bit, tx_ir_pulse, rx_line_pin, serial_output_pin;
  logic [1:0]        rx_line_bit, tx_parity_bit, tx_start, rx_start, transmit_enable_bit;
  logic [1:0]        receive_enable_bit, clock_sync_mode;
  logic [7:0]        rx_char_0, rx_char_1, tx_char_0, tx_char_1;
  int                err_total = 0;
  int                checked = 0;
  int                cycles = 0;
  serial_error_irda_interrupt dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .cpu_irq_mask, .rx_char_done, .rx_char_0, .rx_char_1, .rx_stop_bit,
    .serial_half_tick, .tx_shift_done, .tx_char_0, .tx_char_1, .tx_serial_bit, .tx_ir_pulse,
    .rx_line_pin, .serial_output_pin, .rx_line_bit, .tx_parity_bit, .tx_start, .rx_start,
    .transmit_enable_bit, .receive_enable_bit, .clock_sync_mode, .irq_request, .irq_level);
  far_end far (.clk, .rx_char_done, .rx_char_0, .rx_char_1, .rx_stop_bit, .serial_half_tick,
    .tx_shift_done, .tx_char_0, .tx_char_1, .tx_serial_bit, .tx_ir_pulse, .rx_line_pin);
  // ----------
  // Clock and watchdog
  // ----------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      tally_and_finish();
    end
  end
  // ----------
  // Bus and check tasks
  // ----------
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task rchk(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk($sformatf("reg %h", a), e, reg_rdata & m);
  endtask
  task mask(input logic [1:0] m);
    @(posedge clk);
    cpu_irq_mask <= m;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask
  task tally_and_finish();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ----------
  // Tests
  // ----------
  initial begin
    logic [15:0] regs [7];
    int          k;
    int          c;
    logic        p;
    regs = '{A_PRIO, A_EN, A_FLAG, A_CTRL0, A_IR0, A_CTRL1, 16'h0000};
    rst = 1'b1;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    cpu_irq_mask = 2'h1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    foreach (regs[i]) rchk(regs[i], 8'hff, 8'h00);
    wr(A_EN, 8'h77);
    rchk(A_EN, 8'h77, 8'h77);
    wr(A_PRIO, 8'h0e);
    rchk(A_PRIO, 8'h0f, 8'h0e);
    wr(A_EN, 8'h04);
    for (k = 0; k < 32; k++) begin
      c = k / 16;
      p = k[0];
      wr(c ? A_IR1 : A_IR0, {k[3], k[2], 1'b0, k[1], 4'h0});
      rchk(c ? A_IR1 : A_IR0, 8'hd0, {k[3], k[2], 1'b0, k[1], 4'h0});
      far.line(c, p);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("out pin", {7'h0, k[1] & k[3] ? p : ~p}, {7'h0, serial_output_pin[c]});
      chk("in bit", {7'h0, k[1] & k[2] ? ~p : p}, {7'h0, rx_line_bit[c]});
    end
    wr(A_MODE0, 8'h40);
    wr(A_CTRL0, 8'h0c);
    @(negedge clk);
    chk("rx start", 8'h01, {7'h0, rx_start[0]});
    far.deliver(0, 8'h01, 1'b1);
    rchk(A_FLAG, 8'h77, 8'h04);
    rchk(A_CTRL0, 8'h74, 8'h24);
    chk("irq", 8'h01, {7'h0, irq_request});
    chk("level", 8'h02, {6'h0, irq_level});
    mask(2'h2);
    chk("irq", 8'h00, {7'h0, irq_request});
    mask(2'h3);
    mask(2'h1);
    far.tick(0);
    rchk(A_FLAG, 8'h77, 8'h06);
    wr(A_CTRL0, 8'h04);
    rchk(A_CTRL0, 8'h74, 8'h24);
    wr(A_FLAG, 8'h00);
    rchk(A_FLAG, 8'h77, 8'h06);
    wr(A_CTRL0, 8'h2c);
    wr(A_FLAG, 8'h06);
    rchk(A_CTRL0, 8'h74, 8'h04);
    rchk(A_FLAG, 8'h77, 8'h00);
    far.deliver(0, 8'h03, 1'b0);
    far.tick(0);
    rchk(A_CTRL0, 8'h74, 8'h44);
    rchk(A_FLAG, 8'h77, 8'h06);
    wr(A_FLAG, 8'h06);
    wr(A_CTRL0, 8'h44);
    rchk(A_CTRL0, 8'h74, 8'h04);
    far.deliver(0, 8'h03, 1'b1);
    far.tick(0);
    rchk(A_CTRL0, 8'h74, 8'h14);
    rchk(A_FLAG, 8'h77, 8'h04);
    wr(A_CTRL0, 8'h00);
    wr(A_FLAG, 8'h77);
    far.deliver(0, 8'h01, 1'b0);
    rchk(A_CTRL0, 8'h74, 8'h00);
    rchk(A_FLAG, 8'h77, 8'h00);
    wr(A_MODE1, 8'h01);
    wr(A_CTRL1, 8'h0c);
    wr(A_CTRL1, 8'h07);
    rchk(A_CTRL1, 8'h0f, 8'h0d);
    far.deliver(1, 8'h01, 1'b0);
    far.tick(1);
    rchk(A_CTRL1, 8'h7c, 8'h04);
    rchk(A_FLAG, 8'h77, 8'h20);
    wr(A_FLAG, 8'h20);
    wr(A_CTRL1, 8'h00);
    for (k = 0; k < 2; k++) begin
      wr(k ? A_MODE1 : A_MODE0, 8'h60);
      wr(k ? A_CTRL1 : A_CTRL0, 8'h03);
      @(negedge clk);
      chk("tx start", 8'h01, {7'h0, tx_start[k]});
      far.txchar(8'h07);
      far.shifted(k);
      rchk(A_FLAG, 8'h77, k ? 8'h10 : 8'h01);
      chk("parity", 8'h00, {7'h0, tx_parity_bit[k]});
      chk("irq", 8'h00, {7'h0, irq_request});
      wr(A_FLAG, 8'h11);
      wr(k ? A_CTRL1 : A_CTRL0, 8'h00);
    end
    tally_and_finish();
  end
endmodule
